// [design/fcs_pkg.sv]
// Constants and types of the flash CRC scan control block
//
// Contract
// - A one written to the reset strobe clears the control A enable bit, control B and status one clock after the write.
// - With the NMI trigger enable low, the reset strobe is accepted busy or not and acts one clock after the write.
// - With the NMI trigger enable high, the reset strobe is ignored while a check is busy.
// - The reset bit is a strobe that acts on the write and never holds a stored value.
// - With the NMI trigger enable set, any CRC failure raises the non-maskable request.
// - The NMI trigger enable, once set, is cleared only by system reset, not by the strobe or a zero write.
// - The NMI trigger enable can be written to one only while no check is busy.
// - Once the checker has raised its non-maskable request, control A accepts no more writes.
// - Writing one to the enable bit starts a check with the settings held in the control registers.
// - The enable bit keeps reading one after a check completes, and a new one launches a fresh check.
// - Writing zero to the enable bit does not abort a running check, which ends at its section end.
// - A failure in a check finishing after enable was cleared is still caught and can raise the request.
// - A check can be started during reset initialisation, before the processor runs code.
// - Control A holds the reset strobe at bit 7, NMI trigger enable at bit 1, enable at bit 0, all reset zero.
package fcs_pkg;
  // Bus widths
  localparam int unsigned APB_AW = 12;
  localparam int unsigned APB_DW = 32;
  localparam int unsigned FLASH_AW = 16;

  // Register indices and byte addresses
  localparam logic [1:0] IDX_CTRL_A = 2'h0;
  localparam logic [1:0] IDX_CTRL_B = 2'h1;
  localparam logic [1:0] IDX_STATUS = 2'h2;
  localparam logic [APB_AW-1:0] ADDR_CTRL_A = {8'h00, IDX_CTRL_A, 2'h0};
  localparam logic [APB_AW-1:0] ADDR_CTRL_B = {8'h00, IDX_CTRL_B, 2'h0};
  localparam logic [APB_AW-1:0] ADDR_STATUS = {8'h00, IDX_STATUS, 2'h0};

  // Field positions
  localparam int unsigned CA_RESET_BIT = 7;
  localparam int unsigned CA_NMI_TRIGGER_ENABLE_BIT = 1;
  localparam int unsigned CA_ENABLE_BIT = 0;
  localparam int unsigned CB_MODE_LSB = 4;
  localparam int unsigned CB_SRC_LSB = 0;
  localparam int unsigned ST_BUSY_BIT = 0;
  localparam int unsigned ST_OK_BIT = 1;
  localparam logic [7:0] CB_WR_MASK = 8'h33;

  // Reset values
  localparam logic [7:0] CTRL_B_RST = 8'h00;

  // Mode and source encodings
  localparam logic [1:0] MODE_ONCE = 2'h0;
  localparam logic [1:0] SRC_FULL = 2'h0;
  localparam logic [1:0] SRC_APP = 2'h1;
  localparam logic [1:0] SRC_BOOT = 2'h2;

  // Flash and CRC
  localparam logic [FLASH_AW-1:0] FLASH_LAST = 16'hFFFF;
  localparam logic [15:0] CRC_POLY = 16'h1021;
  localparam logic [15:0] CRC_INIT = 16'hFFFF;
  localparam logic [15:0] CRC_RESIDUE = 16'h0000;

  // APB request and answer
  typedef struct packed {
    logic [APB_AW-1:0] paddr;
    logic psel;
    logic penable;
    logic pwrite;
    logic [APB_DW-1:0] pwdata;
    logic [3:0] pstrb;
  } fcs_apb_req_s;

  typedef struct packed {
    logic [APB_DW-1:0] prdata;
    logic pready;
    logic pslverr;
  } fcs_apb_rsp_s;
endpackage : fcs_pkg

// [design/fcs_flash_crc_checker.sv]
// Flash CRC scan control block with APB register slave
//
// Register access over APB was decided locally.
`timescale 1ns/10ps
module fcs_flash_crc_checker (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  // APB slave
  input wire fcs_pkg::fcs_apb_req_s i_apb,
  output fcs_pkg::fcs_apb_rsp_s o_apb,
  // Section limits and reset-time start
  input wire logic [fcs_pkg::FLASH_AW-1:0] i_boot_end,
  input wire logic [fcs_pkg::FLASH_AW-1:0] i_app_end,
  input wire logic i_init_scan,
  // Flash read port
  output logic o_flash_rd,
  output logic [fcs_pkg::FLASH_AW-1:0] o_flash_addr,
  input wire logic [7:0] i_flash_data,
  // Non-maskable request
  output logic o_nmi_req
);
  import fcs_pkg::*;

  typedef enum logic [1:0] {ST_IDLE, ST_READ, ST_ACC} fcs_state_e;

  fcs_state_e state_ff;
  logic [7:0] ctrl_b_ff;
  logic enable_ff;
  logic nmi_trigger_enable_ff;
  logic clear_pend_ff;
  logic busy_ff;
  logic ok_ff;
  logic [15:0] crc_ff;
  logic [FLASH_AW-1:0] end_ff;

  // One CRC byte step, MSB first
  function automatic logic [15:0] crc_byte(input logic [15:0] crc, input logic [7:0] data);
    logic [15:0] c;
    c = crc ^ {data, 8'h00};
    for (int i = 0; i < 8; i++) begin
      c = c[15] ? ((c << 1) ^ CRC_POLY) : (c << 1);
    end
    return c;
  endfunction : crc_byte

  // APB decode
  wire setup = i_apb.psel & ~i_apb.penable;
  wire wr_fire = i_apb.psel & i_apb.penable & i_apb.pwrite & o_apb.pready & i_apb.pstrb[0];
  wire hit_a = i_apb.paddr == ADDR_CTRL_A;
  wire hit_b = i_apb.paddr == ADDR_CTRL_B;
  wire hit_st = i_apb.paddr == ADDR_STATUS;
  wire hit_any = hit_a | hit_b | hit_st;
  wire [7:0] wdata = i_apb.pwdata[7:0];

  // Control A and control B write qualification
  wire wr_a = wr_fire & hit_a & ~o_nmi_req;
  wire wr_b = wr_fire & hit_b;
  wire rst_strobe = wr_a & wdata[CA_RESET_BIT] & (~nmi_trigger_enable_ff | ~busy_ff);
  wire set_nmi_trigger_enable = wr_a & wdata[CA_NMI_TRIGGER_ENABLE_BIT] & ~busy_ff;
  wire start_sw = wr_a & wdata[CA_ENABLE_BIT] & ~rst_strobe;

  // Read data, strobe bit always reads zero
  wire [7:0] rd_a = {6'h00, nmi_trigger_enable_ff, enable_ff};
  wire [7:0] rd_st = {6'h00, ok_ff, busy_ff};
  wire [7:0] rdata = hit_a ? rd_a : (hit_b ? ctrl_b_ff : (hit_st ? rd_st : 8'h00));

  // Scan control decode
  wire [1:0] mode = ctrl_b_ff[CB_MODE_LSB +: 2];
  wire [1:0] src = ctrl_b_ff[CB_SRC_LSB +: 2];
  wire auto_restart = enable_ff & (mode != MODE_ONCE);
  wire start_ok = (state_ff == ST_IDLE) & ~clear_pend_ff & (start_sw | i_init_scan | auto_restart);
  wire [FLASH_AW-1:0] sel_end = (src == SRC_APP) ? i_app_end : ((src == SRC_BOOT) ? i_boot_end : FLASH_LAST);
  wire [15:0] crc_next = crc_byte(crc_ff, i_flash_data);
  wire done = (state_ff == ST_ACC) & (o_flash_addr == end_ff) & ~clear_pend_ff;
  wire fail = done & (crc_next != CRC_RESIDUE);

  // APB answer, zero wait states
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      o_apb <= '0;
    end else begin
      o_apb.pready <= setup;
      o_apb.pslverr <= setup & ~hit_any;
      o_apb.prdata <= setup ? {24'h000000, rdata} : '0;
    end
  end

  // Strobe takes effect one cycle after its write
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      clear_pend_ff <= 1'b0;
    end else begin
      clear_pend_ff <= rst_strobe;
    end
  end

  // Control A enable and sticky NMI trigger enable
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      enable_ff <= 1'b0;
      nmi_trigger_enable_ff <= 1'b0;
    end else begin
      if (clear_pend_ff) begin
        enable_ff <= 1'b0;
      end else if (wr_a & ~rst_strobe) begin
        enable_ff <= wdata[CA_ENABLE_BIT];
      end else if (i_init_scan) begin
        enable_ff <= 1'b1;
      end
      nmi_trigger_enable_ff <= nmi_trigger_enable_ff | set_nmi_trigger_enable;
    end
  end

  // Control B, sampled by a check only at its start
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      ctrl_b_ff <= CTRL_B_RST;
    end else if (clear_pend_ff) begin
      ctrl_b_ff <= CTRL_B_RST;
    end else if (wr_b) begin
      ctrl_b_ff <= wdata & CB_WR_MASK;
    end
  end

  // Scan sequencer: one flash byte per two cycles
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      state_ff <= ST_IDLE;
      busy_ff <= 1'b0;
      ok_ff <= 1'b0;
      crc_ff <= CRC_INIT;
      end_ff <= '0;
      o_flash_addr <= '0;
      o_flash_rd <= 1'b0;
    end else if (clear_pend_ff) begin
      state_ff <= ST_IDLE;
      busy_ff <= 1'b0;
      ok_ff <= 1'b0;
      o_flash_rd <= 1'b0;
    end else begin
      unique case (state_ff)
        ST_IDLE: begin
          if (start_ok) begin
            state_ff <= ST_READ;
            busy_ff <= 1'b1;
            ok_ff <= 1'b0;
            crc_ff <= CRC_INIT;
            end_ff <= sel_end;
            o_flash_addr <= '0;
            o_flash_rd <= 1'b1;
          end
        end
        ST_READ: begin
          state_ff <= ST_ACC;
          o_flash_rd <= 1'b0;
        end
        ST_ACC: begin
          crc_ff <= crc_next;
          if (done) begin
            state_ff <= ST_IDLE;
            busy_ff <= 1'b0;
            ok_ff <= ~fail;
          end else begin
            state_ff <= ST_READ;
            o_flash_addr <= o_flash_addr + 1'b1;
            o_flash_rd <= 1'b1;
          end
        end
        default: begin
          state_ff <= ST_IDLE;
        end
      endcase
    end
  end

  // Non-maskable request, held until system reset
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      o_nmi_req <= 1'b0;
    end else if (fail & nmi_trigger_enable_ff) begin
      o_nmi_req <= 1'b1;
    end
  end

  // Checks
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_sys_rst);

  chk_strobe_clears_regs: assert property (
    rst_strobe |-> ##2 (ctrl_b_ff == CTRL_B_RST && !busy_ff && !ok_ff && !enable_ff))
    else $error("reset strobe did not clear registers two edges later");

  chk_strobe_free_idle: assert property (
    (wr_a && wdata[CA_RESET_BIT] && !nmi_trigger_enable_ff) |=> clear_pend_ff)
    else $error("reset strobe not accepted with nmi enable low");

  chk_strobe_busy_block: assert property (
    (wr_a && wdata[CA_RESET_BIT] && nmi_trigger_enable_ff && busy_ff) |=> !clear_pend_ff ##1 $stable(ctrl_b_ff))
    else $error("reset strobe acted while busy with nmi enable high");

  chk_nmi_trigger_enable_sticky: assert property (
    nmi_trigger_enable_ff |=> nmi_trigger_enable_ff)
    else $error("nmi trigger enable cleared without system reset");

  chk_nmi_trigger_enable_idle_set: assert property (
    $rose(nmi_trigger_enable_ff) |-> !$past(busy_ff))
    else $error("nmi trigger enable set while busy");

  chk_nmi_on_fail: assert property (
    (fail && nmi_trigger_enable_ff) |=> o_nmi_req ##1 o_nmi_req)
    else $error("failure with nmi enable did not raise request");

  chk_ctrl_a_locked: assert property (
    (o_nmi_req && !clear_pend_ff && !i_init_scan) |=> ($stable(enable_ff) && !clear_pend_ff))
    else $error("control A changed after nmi was raised");

  chk_start_busy: assert property (
    start_ok |=> (busy_ff && state_ff == ST_READ && o_flash_rd && o_flash_addr == '0))
    else $error("check did not start on enable");

  chk_enable_holds: assert property (
    (done && enable_ff && !wr_a) |=> (enable_ff && !busy_ff))
    else $error("enable bit dropped at check completion");

  chk_no_abort: assert property (
    (state_ff == ST_READ && wr_a && !wdata[CA_ENABLE_BIT] && !rst_strobe && !clear_pend_ff)
      |=> (busy_ff && state_ff == ST_ACC))
    else $error("enable zero write aborted running check");

  chk_init_start: assert property (
    (i_init_scan && state_ff == ST_IDLE && !clear_pend_ff) |=> (busy_ff && enable_ff))
    else $error("reset-time scan request did not start a check");

  chk_pass_on_match: assert property (
    (done && crc_next == CRC_RESIDUE) |=> (ok_ff && !busy_ff))
    else $error("pass not set on matching crc");

  chk_apb_answer: assert property (
    (setup && hit_a) |=> (o_apb.pready && o_apb.prdata[CA_RESET_BIT] == 1'b0 && !o_apb.pslverr))
    else $error("control A read answer wrong");

  // Request stays up once raised
  chk_nmi_sticky: assert property (
    o_nmi_req |=> o_nmi_req)
    else $error("nmi request dropped without system reset");

  // Request only from a failure with the trigger enabled
  chk_nmi_cause: assert property (
    $rose(o_nmi_req) |-> ($past(fail) && $past(nmi_trigger_enable_ff)))
    else $error("nmi request raised without an enabled failure");

  // No request while the trigger is disabled
  chk_nmi_disabled: assert property (
    (fail && !nmi_trigger_enable_ff && !o_nmi_req) |=> !o_nmi_req)
    else $error("nmi request raised with trigger disabled");

  // Strobe leaves the trigger enable alone
  chk_nmi_trigger_enable_strobe: assert property (
    (nmi_trigger_enable_ff && clear_pend_ff) |=> nmi_trigger_enable_ff)
    else $error("reset strobe cleared nmi trigger enable");

  // Trigger enable refused while busy
  chk_nmi_trigger_enable_busy_ref: assert property (
    (wr_a && wdata[CA_NMI_TRIGGER_ENABLE_BIT] && busy_ff && !nmi_trigger_enable_ff) |=> !nmi_trigger_enable_ff)
    else $error("nmi trigger enable set during a busy check");

  // No control A action after the request
  chk_ctrl_a_blocked: assert property (
    o_nmi_req |-> (!rst_strobe && !set_nmi_trigger_enable && !start_sw))
    else $error("control A write acted after nmi request");

  // Enable bit stored on a one write
  chk_enable_stored: assert property (
    (wr_a && wdata[CA_ENABLE_BIT] && !rst_strobe && !clear_pend_ff) |=> enable_ff)
    else $error("enable bit not stored on write of one");

  // Start seeds the CRC
  chk_start_seed: assert property (
    start_ok |=> (crc_ff == CRC_INIT))
    else $error("crc not seeded at check start");

  // Start latches the section end
  chk_start_end: assert property (
    start_ok |=> (end_ff == $past(sel_end)))
    else $error("section end not latched at check start");

  // Read request lasts one cycle
  chk_read_pulse: assert property (
    o_flash_rd |=> !o_flash_rd)
    else $error("flash read request longer than one cycle");

  // Rewrite of enable relaunches when idle
  chk_scan_relaunch: assert property (
    (start_sw && state_ff == ST_IDLE && !clear_pend_ff) |=> busy_ff)
    else $error("enable rewrite did not launch a check");

  // Scan keeps going until the section end
  chk_run_to_end: assert property (
    (state_ff == ST_ACC && o_flash_addr != end_ff && !clear_pend_ff) |=> busy_ff)
    else $error("check ended before section end");

  // Address walks up one byte at a time
  chk_addr_step: assert property (
    (state_ff == ST_ACC && !done && !clear_pend_ff) |=> (o_flash_addr == $past(o_flash_addr) + 16'h0001))
    else $error("flash address did not step by one");

  // Section end returns to idle
  chk_done_idle: assert property (
    done |=> (state_ff == ST_IDLE))
    else $error("sequencer not idle after section end");

  // Late failure still reaches the request
  chk_late_fail: assert property (
    (fail && !enable_ff && nmi_trigger_enable_ff) |=> o_nmi_req)
    else $error("failure after enable cleared did not raise request");

  // Reset-time start sets enable
  chk_init_enable: assert property (
    (i_init_scan && !wr_a && !clear_pend_ff) |=> enable_ff)
    else $error("reset-time scan did not set enable");

  // Busy follows the sequencer
  chk_busy_running: assert property (
    (state_ff != ST_IDLE) |-> busy_ff)
    else $error("busy low while sequencer runs");

  // Busy low when idle
  chk_idle_not_busy: assert property (
    (state_ff == ST_IDLE) |-> !busy_ff)
    else $error("busy high while sequencer idle");

  // Failure leaves pass low
  chk_fail_no_pass: assert property (
    fail |=> (!ok_ff && !busy_ff))
    else $error("pass set after failing check");

  // Pass cleared as a check starts
  chk_start_clr_ok: assert property (
    start_ok |=> !ok_ff)
    else $error("pass not cleared at check start");

  // Unmapped address answered with an error
  chk_unmapped_err: assert property (
    (setup && !hit_any) |=> (o_apb.pready && o_apb.pslverr && o_apb.prdata == '0))
    else $error("unmapped access not answered with error");

  // Upper read lanes stay zero
  chk_upper_zero: assert property (
    o_apb.prdata[31:8] == 24'h000000)
    else $error("upper read data lanes not zero");
endmodule : fcs_flash_crc_checker

// [verification/tb_top.sv]
// Self-checking bench for the flash CRC scan control block
`timescale 1ns/10ps
module tb_top;
  import fcs_pkg::*;
  logic i_core_clk = 1'b0;
  logic i_sys_rst = 1'b1;
  fcs_apb_req_s apb_req = '0;
  fcs_apb_rsp_s apb_rsp;
  logic init_scan = 1'b0;
  logic flash_rd;
  logic [FLASH_AW-1:0] flash_addr;
  logic [7:0] flash_data = 8'h00;
  logic nmi_req;
  logic [7:0] mem [0:15];
  int bad_count = 0;
  int total_checks = 0;

  // Clock generation
  always #5 i_core_clk = ~i_core_clk;

  fcs_flash_crc_checker dut (.i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst), .i_apb(apb_req), .o_apb(apb_rsp),
    .i_boot_end(16'h000F), .i_app_end(16'h001F), .i_init_scan(init_scan), .o_flash_rd(flash_rd),
    .o_flash_addr(flash_addr), .i_flash_data(flash_data), .o_nmi_req(nmi_req));

  // Flash answers one cycle after a read; idle data keeps toggling
  always @(posedge i_core_clk) begin
    flash_data <= flash_rd ? mem[flash_addr[3:0]] : ~flash_data;
  end

  task automatic wrap_up();
    $display("Checks %0d, mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : wrap_up

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // One APB transfer, held until pready is seen high
  task automatic apb(input logic wr, input logic [APB_AW-1:0] a, input logic [7:0] d,
                     output logic [31:0] rd, output logic er);
    int n;
    @(posedge i_core_clk);
    apb_req.psel <= 1'b1;
    apb_req.penable <= 1'b0;
    apb_req.pwrite <= wr;
    apb_req.paddr <= a;
    apb_req.pwdata <= {24'h000000, d};
    apb_req.pstrb <= 4'hF;
    @(posedge i_core_clk);
    apb_req.penable <= 1'b1;
    n = 0;
    do begin
      @(posedge i_core_clk);
      n++;
    end while (apb_rsp.pready !== 1'b1 && n < 20);
    if (apb_rsp.pready !== 1'b1) begin
      bad_count++;
      $display("Error at %0t: no pready on APB transfer", $time);
    end
    rd = apb_rsp.prdata;
    er = apb_rsp.pslverr;
    apb_req.psel <= 1'b0;
    apb_req.penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [APB_AW-1:0] a, input logic [7:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask : wr

  task automatic rchk(input logic [APB_AW-1:0] a, input logic [7:0] exp);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 8'h00, r, e);
    chk(r, {24'h000000, exp});
  endtask : rchk

  // Polls status until the check ends, bounded
  task automatic wait_idle();
    logic [31:0] r;
    logic e;
    int n;
    n = 0;
    do begin
      apb(1'b0, ADDR_STATUS, 8'h00, r, e);
      n++;
    end while (r[ST_BUSY_BIT] !== 1'b0 && n < 60);
    if (r[ST_BUSY_BIT] !== 1'b0) begin
      bad_count++;
      $display("Error at %0t: check still busy after polling", $time);
    end
  endtask : wait_idle

  // Watchdog
  initial begin
    repeat (8000) @(posedge i_core_clk);
    bad_count++;
    wrap_up();
  end

  // Main sequence
  initial begin
    logic [15:0] c;
    logic [31:0] r;
    logic e;
    c = CRC_INIT;
    for (int i = 0; i < 14; i++) begin
      mem[i] = 8'(i * 37 + 5);
      c = c ^ {mem[i], 8'h00};
      for (int b = 0; b < 8; b++) begin
        c = c[15] ? ((c << 1) ^ CRC_POLY) : (c << 1);
      end
    end
    mem[14] = c[15:8];
    mem[15] = c[7:0];
    repeat (16) @(posedge i_core_clk);
    i_sys_rst <= 1'b0;
    rchk(ADDR_CTRL_A, 8'h00);
    rchk(ADDR_CTRL_B, 8'h00);
    rchk(ADDR_STATUS, 8'h00);
    apb(1'b0, 12'h00C, 8'h00, r, e);
    chk({31'h0, e}, 32'h1);
    wr(ADDR_STATUS, 8'hFF);
    rchk(ADDR_STATUS, 8'h00);
    $display("Test reset_values done");
    wr(ADDR_CTRL_B, 8'h02);
    wr(ADDR_CTRL_A, 8'h01);
    rchk(ADDR_STATUS, 8'h01);
    wr(ADDR_CTRL_A, 8'h02);
    rchk(ADDR_CTRL_A, 8'h00);
    rchk(ADDR_STATUS, 8'h01);
    wait_idle();
    rchk(ADDR_STATUS, 8'h02);
    wr(ADDR_CTRL_A, 8'h01);
    wait_idle();
    rchk(ADDR_CTRL_A, 8'h01);
    wr(ADDR_CTRL_A, 8'h01);
    rchk(ADDR_STATUS, 8'h01);
    $display("Test scan_start done");
    wr(ADDR_CTRL_A, 8'h80);
    rchk(ADDR_CTRL_A, 8'h00);
    rchk(ADDR_CTRL_B, 8'h00);
    rchk(ADDR_STATUS, 8'h00);
    $display("Test strobe_busy done");
    wr(ADDR_CTRL_A, 8'h02);
    rchk(ADDR_CTRL_A, 8'h02);
    wr(ADDR_CTRL_A, 8'h80);
    rchk(ADDR_CTRL_A, 8'h02);
    wr(ADDR_CTRL_A, 8'h00);
    rchk(ADDR_CTRL_A, 8'h02);
    wr(ADDR_CTRL_B, 8'h02);
    mem[3] = ~mem[3];
    wr(ADDR_CTRL_A, 8'h03);
    wr(ADDR_CTRL_A, 8'h82);
    rchk(ADDR_CTRL_A, 8'h02);
    rchk(ADDR_STATUS, 8'h01);
    chk({31'h0, nmi_req}, 32'h0);
    wait_idle();
    @(posedge i_core_clk);
    chk({31'h0, nmi_req}, 32'h1);
    wr(ADDR_CTRL_A, 8'h01);
    rchk(ADDR_CTRL_A, 8'h02);
    rchk(ADDR_STATUS, 8'h00);
    $display("Test nmi_path done");
    i_sys_rst <= 1'b1;
    repeat (16) @(posedge i_core_clk);
    i_sys_rst <= 1'b0;
    mem[3] = ~mem[3];
    chk({31'h0, nmi_req}, 32'h0);
    wr(ADDR_CTRL_B, 8'h02);
    @(posedge i_core_clk);
    init_scan <= 1'b1;
    @(posedge i_core_clk);
    init_scan <= 1'b0;
    rchk(ADDR_STATUS, 8'h01);
    rchk(ADDR_CTRL_A, 8'h01);
    wait_idle();
    rchk(ADDR_STATUS, 8'h02);
    $display("Test init_scan done");
    wrap_up();
  end
endmodule : tb_top
